// ### rtl/adsq_sequencer.sv
`timescale 1ns/1ps
`include "adsq_map.svh"

// Behaviour
// R1: ADC mode makes a 10-bit two's-complement result, single-ended against half supply.
// R2: Differential select high measures positive pin against negative pin of a pair.
// R3: Channel select picks one of six pins or one of three pin pairs.
// R4: Software clears input connect around channel changes; inputs pass only when set.
// R5: Software leaves connect and channel alone while busy; pins set input-only.
// R6: Channel six uses no pin; reference select picks supply or temperature.
// R7: Internal channels use internal reference as full scale and negative input.
// R8: Converter enable powers the converter; clearing it stops all activity.
// R9: ADC conversion lasts 13 converter cycles, sampling in the third.
// R10: ADC end sets done flag and writes both result bytes.
// R11: Done flag reaches system one converter cycle plus two system clocks later.
// R12: Result bytes hold until next completion; read-only in ADC mode.
// R13: DAC mode drives a differential output pair around half supply.
// R14: DAC mode needs enable and DAC bit; ignores input selects; pins input-only.
// R15: DAC conversion lasts 11 cycles, builds from cycle two, releases in cycle 7.
// R16: DAC result bytes write-only; buffer captures them in one system clock at start.
// R17: Software keeps converter clock no faster than CPU clock in DAC mode.
// R18: Default converter clock is internal 8 MHz oscillator divided to 2 MHz.
// R19: Alternative clock is system oscillator through a 7-bit prescaler.
// R20: Start write with converter enabled begins one conversion; busy clears at completion.
// R21: Selected timer overflow starts a conversion; busy held high while running.
// R22: Timer overflow period must exceed one whole conversion.
// R23: Done flag cleared by hardware when the converter interrupt is vectored.
// R24: Right adjust sign-extends upper six bits; left adjust zeroes lower six.
// R25: Prescale code zero selects oscillator over four; others divide by 2 to 128.
// R26: A start arriving while busy is ignored and does not extend the conversion.
module adsq_sequencer #(
  parameter int RES_BITS = `ADSQ_RES_BITS
) (
  input  wire logic                i_clock,
  input  wire logic                i_rst_n,
  input  wire logic                i_ce,
  input  wire logic                i_converter_enable,
  input  wire logic                i_dac_mode,
  input  wire logic                i_left_adjust,
  input  wire logic [2:0]          i_clock_prescale,
  input  wire logic                i_input_connect,
  input  wire logic                i_internal_reference_select,
  input  wire logic [1:0]          i_trigger_source_select,
  input  wire logic                i_differential_select,
  input  wire logic [2:0]          i_channel_select,
  input  wire logic                i_start_write,
  input  wire logic [2:0]          i_timer_overflow,
  input  wire logic                i_isr_vector,
  input  wire logic                i_rc_osc_tick,
  input  wire logic                i_osc_tick,
  input  wire logic                i_sar_compare,
  input  wire logic                i_result_high_write,
  input  wire logic                i_result_low_write,
  input  wire logic [7:0]          i_result_write_data,
  output logic                     o_start_busy,
  output logic                     o_conversion_done_flag,
  output logic [7:0]               o_result_high_byte,
  output logic [7:0]               o_result_low_byte,
  output logic                     o_analog_power,
  output logic                     o_converter_tick,
  output logic                     o_sample_hold,
  output logic [RES_BITS-1:0]      o_sar_trial,
  output logic                     o_mux_connect,
  output logic [2:0]               o_mux_channel,
  output logic                     o_mux_differential,
  output logic                     o_sel_supply_monitor,
  output logic                     o_sel_temperature,
  output logic                     o_ref_internal,
  output logic [RES_BITS-1:0]      o_dac_value,
  output logic                     o_dac_release,
  output logic                     o_dac_pins_input_only
);

  logic                   rst_s1_q;
  logic                   rst_s2_q;
  logic                   rst_n;
  adsq_pkg::adsq_phase_e  phase_q;
  adsq_pkg::adsq_cycle_t  cyc_q;
  logic                   dac_run_q;
  logic [1:0]             rc_div_q;
  logic [6:0]             pre_div_q;
  logic                   tick;
  logic                   dac_on;
  logic                   start_req;
  logic                   start_ok;
  logic                   last_cyc;
  logic [3:0]             bit_idx;
  logic [RES_BITS-1:0]    sar_q;
  logic [RES_BITS-1:0]    sar_fin;
  logic [RES_BITS-1:0]    dac_buf_q;
  logic [RES_BITS-1:0]    signed_res;
  logic [RES_BITS-1:0]    buf_src;
  logic [6:0]             pre_mask;
  logic                   done_evt_q;
  logic                   done_s1_q;
  logic [15:0]            result_q;

  // Reset release through two flops
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  assign dac_on = i_converter_enable & i_dac_mode; // R14

  // Converter clock as an enable; prescaler mask selects 2..128
  assign pre_mask = 7'h7F >> (3'h7 - i_clock_prescale); // R25

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      rc_div_q  <= 2'h0;
      pre_div_q <= 7'h00;
      o_converter_tick <= 1'b0;
    end else if (i_ce) begin
      o_converter_tick <= 1'b0;
      // Internal oscillator keeps the divider running regardless of system clock source
      if (i_rc_osc_tick) begin
        rc_div_q <= rc_div_q + 2'h1; // R18
      end
      if (i_osc_tick) begin
        pre_div_q <= pre_div_q + 7'h01; // R19
      end
      if (!i_converter_enable) begin
        o_converter_tick <= 1'b0; // R8
      end else if (i_clock_prescale == 3'h0) begin
        o_converter_tick <= i_rc_osc_tick && (rc_div_q == `ADSQ_RC_DIV_LAST); // R25
      end else begin
        o_converter_tick <= i_osc_tick && ((pre_div_q & pre_mask) == pre_mask); // R19
      end
    end
  end
  assign tick = o_converter_tick;

  // Start sources: software write or the chosen timer overflow
  always_comb begin
    if (i_trigger_source_select == `ADSQ_TRG_SOFTWARE) begin
      start_req = i_start_write; // R20
    end else begin
      start_req = i_timer_overflow[i_trigger_source_select - 2'h1]; // R21
    end
  end
  // Busy or finishing conversions drop new starts
  assign start_ok = i_converter_enable && (phase_q == adsq_pkg::ADSQ_IDLE) && start_req; // R26
  // Count holds finished cycles, so the closing tick finds length minus one
  assign last_cyc = (cyc_q == (dac_run_q ? (`ADSQ_DAC_CYCLES - 4'h1) : (`ADSQ_ADC_CYCLES - 4'h1))); // R9 R15

  // Sequencer phase and cycle count
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q   <= adsq_pkg::ADSQ_IDLE;
      cyc_q     <= 4'h0;
      dac_run_q <= 1'b0;
      o_start_busy <= 1'b0;
    end else if (i_ce) begin
      if (!i_converter_enable) begin
        phase_q <= adsq_pkg::ADSQ_IDLE; // R8
        cyc_q   <= 4'h0;
        o_start_busy <= 1'b0;
      end else begin
        case (phase_q)
          adsq_pkg::ADSQ_IDLE: begin
            if (start_ok) begin
              phase_q   <= adsq_pkg::ADSQ_RUN;
              cyc_q     <= 4'h0;
              dac_run_q <= i_dac_mode;
              o_start_busy <= 1'b1; // R20 R21
            end
          end
          adsq_pkg::ADSQ_RUN: begin
            if (tick) begin
              if (last_cyc) begin
                phase_q <= adsq_pkg::ADSQ_SYNC;
                o_start_busy <= 1'b0; // R20
              end else begin
                cyc_q <= cyc_q + 4'h1; // R9 R15
              end
            end
          end
          adsq_pkg::ADSQ_SYNC: begin
            // One more converter cycle before the done event leaves
            if (tick) begin
              phase_q <= adsq_pkg::ADSQ_IDLE; // R11
              cyc_q   <= 4'h0;
            end
          end
          default: begin
            phase_q <= adsq_pkg::ADSQ_IDLE;
            o_start_busy <= 1'b0;
          end
        endcase
      end
    end
  end

  // Bit under decision: ADC cycles 4..13, DAC cycles 2..11
  assign bit_idx = dac_run_q ? (`ADSQ_DAC_CYCLES - 4'h1 - cyc_q) : (`ADSQ_ADC_CYCLES - 4'h1 - cyc_q);

  // DAC buffer source, undoing the adjust of the written bytes
  assign buf_src = i_left_adjust ? result_q[15:6] : result_q[9:0];

  // Successive approximation register and DAC buffer
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sar_q     <= '0;
      dac_buf_q <= '0;
    end else if (i_ce) begin
      if (start_ok) begin
        sar_q <= '0;
        if (i_dac_mode) begin
          dac_buf_q <= buf_src; // R16
        end
      end else if ((phase_q == adsq_pkg::ADSQ_RUN) && tick) begin
        if (dac_run_q && (cyc_q >= (`ADSQ_DAC_FIRST_CYC - 4'h1))) begin
          sar_q[bit_idx] <= dac_buf_q[bit_idx]; // R15
        end else if (!dac_run_q && (cyc_q >= `ADSQ_ADC_SAMPLE_CYC)) begin
          // Offset-binary search; comparator high keeps the trial bit
          sar_q[bit_idx] <= i_sar_compare; // R1
        end
      end
    end
  end

  // Bit 0 lands in the same edge as the result, so take it from the comparator
  assign sar_fin    = {sar_q[RES_BITS-1:1], i_sar_compare}; // R1
  // MSB flip turns the offset-binary search into two's complement
  assign signed_res = {~sar_fin[RES_BITS-1], sar_fin[RES_BITS-2:0]}; // R1

  // Result pair: hardware-written in ADC mode, software-written in DAC mode
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= `ADSQ_RESULT_RESET;
    end else if (i_ce) begin
      if ((phase_q == adsq_pkg::ADSQ_RUN) && tick && last_cyc && !dac_run_q) begin
        if (i_left_adjust) begin
          result_q <= {signed_res, {`ADSQ_PAD_BITS{1'b0}}}; // R24 R10
        end else begin
          result_q <= {{`ADSQ_PAD_BITS{signed_res[RES_BITS-1]}}, signed_res}; // R24 R10
        end
      end else if (i_dac_mode) begin
        // Writes ignored in ADC mode so results hold until the next completion
        if (i_result_high_write) begin
          result_q[15:8] <= i_result_write_data; // R16 R12
        end
        if (i_result_low_write) begin
          result_q[7:0] <= i_result_write_data; // R16
        end
      end
    end
  end

  // Readback: write-only in DAC mode reads as zero
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_result_high_byte <= 8'h00;
      o_result_low_byte  <= 8'h00;
    end else if (i_ce) begin
      o_result_high_byte <= i_dac_mode ? 8'h00 : result_q[15:8]; // R12
      o_result_low_byte  <= i_dac_mode ? 8'h00 : result_q[7:0];
    end
  end

  // Done event: one converter cycle late, then two system clocks
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      done_evt_q <= 1'b0;
      done_s1_q  <= 1'b0;
    end else if (i_ce) begin
      done_evt_q <= (phase_q == adsq_pkg::ADSQ_SYNC) && tick; // R11
      done_s1_q  <= done_evt_q;
    end
  end

  // Done flag; a new event wins over the vector clear
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_conversion_done_flag <= 1'b0;
    end else if (i_ce) begin
      if (done_s1_q) begin
        o_conversion_done_flag <= 1'b1; // R10
      end else if (i_isr_vector) begin
        o_conversion_done_flag <= 1'b0; // R23
      end
    end
  end

  // Analog front-end controls
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_analog_power        <= 1'b0;
      o_sample_hold         <= 1'b0;
      o_sar_trial           <= '0;
      o_mux_connect         <= 1'b0;
      o_mux_channel         <= 3'h0;
      o_mux_differential    <= 1'b0;
      o_sel_supply_monitor  <= 1'b0;
      o_sel_temperature     <= 1'b0;
      o_ref_internal        <= 1'b0;
      o_dac_value           <= '0;
      o_dac_release         <= 1'b0;
      o_dac_pins_input_only <= 1'b0;
    end else if (i_ce) begin
      o_analog_power <= i_converter_enable; // R8
      // Sample only in cycle three, held afterwards
      o_sample_hold  <= !dac_run_q && (phase_q == adsq_pkg::ADSQ_RUN) &&
                        (cyc_q == (`ADSQ_ADC_SAMPLE_CYC - 4'h1)); // R9
      o_sar_trial    <= (!dac_run_q && (phase_q == adsq_pkg::ADSQ_RUN) && (cyc_q >= `ADSQ_ADC_SAMPLE_CYC)) ?
                        (sar_q | RES_BITS'(1 << bit_idx)) : sar_q;
      // Connect, differential and internal-source selects act only in ADC mode; the pins are left to software discipline
      o_mux_connect  <= i_converter_enable && !i_dac_mode && i_input_connect &&
                        (i_channel_select != `ADSQ_CH_INTERNAL); // R4 R14
      o_mux_channel  <= i_channel_select; // R3
      o_mux_differential   <= !i_dac_mode && i_differential_select; // R2
      o_sel_supply_monitor <= !i_dac_mode && (i_channel_select == `ADSQ_CH_INTERNAL) &&
                              !i_internal_reference_select; // R6
      o_sel_temperature    <= !i_dac_mode && (i_channel_select == `ADSQ_CH_INTERNAL) &&
                              i_internal_reference_select; // R6
      // Internal channels force the internal reference as scale and negative input
      o_ref_internal <= i_internal_reference_select ||
                        (!i_dac_mode && (i_channel_select == `ADSQ_CH_INTERNAL)); // R7
      o_dac_value    <= dac_buf_q; // R13
      // New value reaches the pins once the five MSBs are built
      if (!dac_on) begin
        o_dac_release <= 1'b0;
      end else if (start_ok) begin
        o_dac_release <= 1'b0; // R15
      end else if (dac_run_q && (phase_q == adsq_pkg::ADSQ_RUN) && (cyc_q >= (`ADSQ_DAC_RELEASE_CYC - 4'h1))) begin
        o_dac_release <= 1'b1; // R15
      end
      o_dac_pins_input_only <= dac_on; // R14
    end
  end

endmodule // adsq_sequencer

// ### rtl/adsq_map.svh
`ifndef ADSQ_MAP_SVH
`define ADSQ_MAP_SVH

// Conversion lengths and event cycles, in converter clock cycles
`define ADSQ_ADC_CYCLES      4'hD
`define ADSQ_DAC_CYCLES      4'hB
`define ADSQ_ADC_SAMPLE_CYC  4'h3
`define ADSQ_DAC_FIRST_CYC   4'h2
`define ADSQ_DAC_RELEASE_CYC 4'h7
// Internal oscillator divide (8 MHz to 2 MHz)
`define ADSQ_RC_DIV_LAST     2'h3
// Channel code that selects the internal sources
`define ADSQ_CH_INTERNAL     3'h6
// Trigger source codes
`define ADSQ_TRG_SOFTWARE    2'h0
// Result width and sign-extension span
`define ADSQ_RES_BITS        10
`define ADSQ_PAD_BITS        6
// Reset values
`define ADSQ_RESULT_RESET    16'h0000

`endif

// ### rtl/adsq_pkg.sv
package adsq_pkg;

  // One-hot sequencer phases
  typedef enum logic [2:0] {
    ADSQ_IDLE = 3'b001,
    ADSQ_RUN  = 3'b010,
    ADSQ_SYNC = 3'b100
  } adsq_phase_e;

  typedef logic [3:0] adsq_cycle_t;

endpackage

// ### dv/adsq_analog.sv
`timescale 1ns/1ps
// Analog front end: comparator against a held input level
module adsq_analog #(
  parameter int RES_BITS = 10
) (
  input  wire logic [RES_BITS-1:0] i_sar_trial,
  input  wire logic [RES_BITS-1:0] i_level,
  output logic                     o_sar_compare
);
  // Signed level shown in offset binary, as the trial is
  assign o_sar_compare = {~i_level[RES_BITS-1], i_level[RES_BITS-2:0]} >= i_sar_trial;
endmodule // adsq_analog

// ### dv/adsq_sequencer_chk.sv
`timescale 1ns/1ps
module adsq_sequencer_chk #(
  parameter int RES_BITS = 10
) (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_converter_enable,
  input wire logic       i_dac_mode,
  input wire logic       i_input_connect,
  input wire logic       i_internal_reference_select,
  input wire logic [2:0] i_channel_select,
  input wire logic       i_isr_vector,
  input wire logic       o_start_busy,
  input wire logic       o_conversion_done_flag,
  input wire logic       o_converter_tick,
  input wire logic       o_sample_hold,
  input wire logic       o_mux_connect,
  input wire logic       o_sel_temperature,
  input wire logic       o_dac_release,
  input wire logic       o_analog_power
);
  logic [1:0] rdy_q;
  logic [4:0] tick_cnt_q;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Reset copy inside lags the pin by two edges
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) rdy_q <= 2'h0;
    else if (rdy_q != 2'h3) rdy_q <= rdy_q + 2'h1;
  end
  // Converter ticks seen while busy
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) tick_cnt_q <= 5'h00;
    else if (!o_start_busy) tick_cnt_q <= 5'h00;
    else if (o_converter_tick) tick_cnt_q <= tick_cnt_q + 5'h01;
  end
  a_busy_length: assert property ($fell(o_start_busy) && $past(i_converter_enable) |->
    tick_cnt_q == ($past(i_dac_mode) ? 5'h0B : 5'h0D)) else $error("busy length wrong");
  a_busy_cause: assert property (rdy_q == 2'h3 && $rose(o_start_busy) |-> $past(i_converter_enable))
    else $error("busy without enable");
  a_sample_third: assert property (o_sample_hold |-> o_start_busy && $past(tick_cnt_q) == 5'h02)
    else $error("sample outside third cycle");
  a_done_after: assert property ($rose(o_conversion_done_flag) |-> !o_start_busy && !$past(o_start_busy, 2))
    else $error("done while busy");
  a_done_clear: assert property ($fell(o_conversion_done_flag) |-> $past(i_isr_vector))
    else $error("done cleared without vector");
  a_tick_pulse: assert property (o_converter_tick |=> !o_converter_tick)
    else $error("tick longer than a clock");
  a_temp_select: assert property (o_sel_temperature |-> $past(i_internal_reference_select)
    && $past(i_channel_select) == 3'h6) else $error("temperature select wrong");
  a_mux_pins: assert property (o_mux_connect |-> $past(i_input_connect) && $past(i_channel_select) != 3'h6)
    else $error("pins connected wrongly");
  a_dac_release: assert property ($rose(o_dac_release) |-> o_start_busy && tick_cnt_q inside {5'h06, 5'h07})
    else $error("release at wrong cycle");
  a_power_off: assert property ((rdy_q == 2'h3 && !i_converter_enable) [*2] |-> !o_analog_power)
    else $error("power on while disabled");
endmodule // adsq_sequencer_chk

bind adsq_sequencer adsq_sequencer_chk #(.RES_BITS(RES_BITS)) u_chk (.i_clock, .i_rst_n, .i_converter_enable,
  .i_dac_mode, .i_input_connect, .i_internal_reference_select, .i_channel_select, .i_isr_vector, .o_start_busy,
  .o_conversion_done_flag, .o_converter_tick, .o_sample_hold, .o_mux_connect, .o_sel_temperature, .o_dac_release,
  .o_analog_power);

// ### dv/adsq_sequencer_test.sv
`timescale 1ns/1ps
module adsq_sequencer_test;
  logic       i_clock = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_converter_enable = 1'b0, i_dac_mode = 1'b0;
  logic       i_left_adjust = 1'b0, i_input_connect = 1'b0, i_internal_reference_select = 1'b0;
  logic       i_differential_select = 1'b0, i_start_write = 1'b0, i_isr_vector = 1'b0, i_rc_osc_tick = 1'b0;
  logic       i_osc_tick = 1'b0, i_result_high_write = 1'b0, i_result_low_write = 1'b0, i_sar_compare;
  logic [2:0] i_clock_prescale = 3'h0, i_channel_select = 3'h0, i_timer_overflow = 3'h0;
  logic [1:0] i_trigger_source_select = 2'h0;
  logic [7:0] i_result_write_data = 8'h00, o_result_high_byte, o_result_low_byte, hv, lv;
  logic [9:0] o_sar_trial, o_dac_value, level = 10'h000;
  logic       o_start_busy, o_conversion_done_flag, o_analog_power, o_converter_tick, o_sample_hold, o_mux_connect;
  logic       o_mux_differential, o_sel_supply_monitor, o_sel_temperature, o_ref_internal, o_dac_release;
  logic       o_dac_pins_input_only;
  logic [2:0] o_mux_channel;
  int         error_cnt = 0, n_tests = 0, cyc = 0, lvl;
  int         seed = 32'h33EBA58C;

  adsq_sequencer u_adsq_sequencer (.i_clock, .i_rst_n, .i_ce, .i_converter_enable, .i_dac_mode, .i_left_adjust,
    .i_clock_prescale, .i_input_connect, .i_internal_reference_select, .i_trigger_source_select,
    .i_differential_select, .i_channel_select, .i_start_write, .i_timer_overflow, .i_isr_vector, .i_rc_osc_tick,
    .i_osc_tick, .i_sar_compare, .i_result_high_write, .i_result_low_write, .i_result_write_data,
    .o_start_busy, .o_conversion_done_flag, .o_result_high_byte, .o_result_low_byte, .o_analog_power,
    .o_converter_tick, .o_sample_hold, .o_sar_trial, .o_mux_connect, .o_mux_channel, .o_mux_differential,
    .o_sel_supply_monitor, .o_sel_temperature, .o_ref_internal, .o_dac_value, .o_dac_release,
    .o_dac_pins_input_only);
  adsq_analog u_adsq_analog (.i_sar_trial(o_sar_trial), .i_level(level), .o_sar_compare(i_sar_compare));

  // 125 MHz clock; oscillator ticks at a quarter and a half of it
  always #4 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    #1 i_osc_tick = ~i_osc_tick;
    i_rc_osc_tick = (cyc % 4 == 0);
    cyc++;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic hi, input logic [7:0] d);
    @(posedge i_clock); #1 {i_result_high_write, i_result_low_write, i_result_write_data} = {hi, ~hi, d};
    @(posedge i_clock); #1 {i_result_high_write, i_result_low_write} = 2'h0;
  endtask
  // Input connect dropped around a channel change, as software must
  task automatic set_chan(input logic [2:0] ch, input logic df);
    @(posedge i_clock); #1 i_input_connect = 1'b0;
    @(posedge i_clock); #1 {i_channel_select, i_differential_select} = {ch, df};
    @(posedge i_clock); #1 i_input_connect = 1'b1;
  endtask
  // One conversion from a given source; a stray start, and in DAC mode a write, mid-run
  task automatic convert(input int src);
    int n;
    @(posedge i_clock); #1;
    if (src == 0) i_start_write = 1'b1;
    else i_timer_overflow[src-1] = 1'b1; // single overflow
    @(posedge i_clock); #1 {i_start_write, i_timer_overflow} = 4'h0;
    chk("busy", 16'h1, {15'h0, o_start_busy});
    repeat (20) @(posedge i_clock);
    #1 {i_start_write, i_timer_overflow, i_result_low_write, i_result_write_data} = {4'hF, i_dac_mode, 8'hA5};
    @(posedge i_clock); #1 {i_start_write, i_timer_overflow, i_result_low_write} = 5'h00;
    n = 0;
    while (o_conversion_done_flag !== 1'b1 && n < 3000) begin
      @(posedge i_clock); #1 n++;
    end
    chk("done", 16'h1, {15'h0, o_conversion_done_flag});
    chk("idle", 16'h0, {15'h0, o_start_busy});
  endtask
  task automatic ack();
    @(posedge i_clock); #1 i_isr_vector = 1'b1;
    @(posedge i_clock); #1 i_isr_vector = 1'b0;
    chk("clear", 16'h0, {15'h0, o_conversion_done_flag});
  endtask

  initial begin
    #(400000);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge i_clock);
    #1 i_rst_n = 1'b1;
    repeat (4) @(posedge i_clock);
    #1 i_start_write = 1'b1; // Disabled converter drops the start
    @(posedge i_clock); #1 i_start_write = 1'b0;
    repeat (2) @(posedge i_clock);
    #1 chk("off", 16'h0, {14'h0, o_start_busy, o_analog_power});
    i_converter_enable = 1'b1;
    // ADC: every trigger source, both adjusts, several clock choices
    for (int k = 0; k < 8; k++) begin
      lvl = $random(seed) % 512;
      level = lvl[9:0];
      set_chan(3'(k % 6), k[0] & (k % 6 < 3));
      {i_trigger_source_select, i_left_adjust, i_clock_prescale} = {2'(k % 4), k[2], 3'(k % 4)};
      repeat (2) @(posedge i_clock);
      #1;
      chk("chan", 16'(k % 6), {13'h0, o_mux_channel});
      chk("differential_select", 16'(k[0] & (k % 6 < 3)), {15'h0, o_mux_differential});
      chk("power", 16'h1, {15'h0, o_analog_power});
      convert(k % 4);
      chk("result", 16'(k[2] ? lvl * 64 : lvl), {o_result_high_byte, o_result_low_byte});
      ack();
    end
    // Internal sources on channel six
    for (int k = 0; k < 2; k++) begin
      set_chan(3'h6, 1'b0);
      i_internal_reference_select = k[0];
      repeat (2) @(posedge i_clock);
      #1;
      chk("internal", 16'(k ? 9 : 5), {12'h0, o_sel_temperature, o_sel_supply_monitor, o_mux_connect, o_ref_internal});
    end
    // DAC: buffer taken at start, later writes do not disturb it
    {i_dac_mode, i_trigger_source_select, i_clock_prescale} = {1'b1, 2'h0, 3'h1};
    for (int k = 0; k < 2; k++) begin
      hv = 8'($random(seed));
      lv = 8'($random(seed));
      i_left_adjust = k[0];
      wr(1'b1, hv);
      wr(1'b0, lv);
      convert(0);
      chk("dac", k ? {6'h00, hv, lv[7:6]} : {6'h00, hv[1:0], lv}, {6'h00, o_dac_value});
      chk("release", 16'h3, {14'h0, o_dac_release, o_dac_pins_input_only});
      chk("readback", 16'h0, {o_result_high_byte, o_result_low_byte});
      ack();
    end
    complete_run();
  end
endmodule // adsq_sequencer_test
